// file: rtl/pdrxq_event_counter.sv
// Purpose: Saturating eight-bit event counter.
// Assumes: Clear has priority over count only when both arrive together.
// Notes: Saturation keeps the count above the debug limit once crossed.
`timescale 1ns/10ps
module pdrxq_event_counter (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Control
    input wire logic i_clear,
    input wire logic i_inc,
    // Count
    output logic [7:0] o_count
);
    logic [7:0] count_reg;
    logic [7:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (i_clear) begin
            count_next = 8'h00;
        end else if (i_inc && count_reg != 8'hFF) begin
            count_next = count_reg + 8'h01;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            count_reg <= 8'h00;
        end else begin
            count_reg <= count_next;
        end
    end

    assign o_count = count_reg;
endmodule : pdrxq_event_counter

// file: rtl/pdrxq_pkg.sv
// Purpose: Shared constants and carriers for the receive packet queue writer.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Pointers are eight bits: a wrap bit above a seven-bit RAM address.
package pdrxq_pkg;

    localparam int RAM_DEPTH = 128;
    localparam int ADDR_W = 7;
    localparam int PTR_W = 8;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MAX_SIZE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FIFO_DATA = 8'h0C;
    localparam logic [7:0] OFS_RD_PTR = 8'h10;
    localparam logic [7:0] OFS_HEAD_PTR = 8'h14;
    localparam logic [7:0] OFS_HEAD_P1_PTR = 8'h18;
    localparam logic [7:0] OFS_CUR_WR_PTR = 8'h1C;
    localparam logic [7:0] OFS_DUP_CNT = 8'h20;
    localparam logic [7:0] OFS_CORRUPT_CNT = 8'h24;
    localparam logic [7:0] OFS_STORED_MESSAGE_ID = 8'h28;

    // Fields of the control register.
    localparam int CTRL_BLOCK_READ_BIT = 0;
    localparam int CTRL_AUTO_ACK_BIT = 1;
    localparam int CTRL_RECEIVER_RESET_BIT = 2;

    // Fields of the status register; bits 1 to 4 are write-one-to-clear flags.
    localparam int STAT_NOT_EMPTY_BIT = 0;
    localparam int STAT_OVERRUN_BIT = 1;
    localparam int STAT_OVERSIZE_BIT = 2;
    localparam int STAT_DROPPED_BIT = 3;
    localparam int STAT_DEBUG_EVENT_BIT = 4;

    // Fields of the queue status byte.
    localparam int QSTAT_VALID_BIT = 0;
    localparam int QSTAT_KIND_LSB = 4;
    localparam logic [7:0] QSTAT_EMPTY_VALUE = 8'h00;

    // Reset values, limits and sizes.
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] MAX_SIZE_RESET = 8'h80;
    localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;
    localparam logic [PTR_W-1:0] HEAD_P1_RESET = 8'h01;
    localparam logic [7:0] COUNT_DEBUG_LIMIT = 8'h7F;
    localparam logic [PTR_W-1:0] HEADER_BYTES = 8'h02;
    localparam logic [PTR_W-1:0] FULL_USED = 8'h80;

    // Kinds of start of frame.
    localparam logic [2:0] KIND_PLAIN = 3'h0;
    localparam logic [2:0] KIND_PRIME = 3'h1;
    localparam logic [2:0] KIND_DOUBLE_PRIME = 3'h2;
    localparam logic [2:0] KIND_PRIME_DEBUG = 3'h3;
    localparam logic [2:0] KIND_DOUBLE_PRIME_DEBUG = 3'h4;
    localparam int KIND_COUNT = 5;

    typedef logic [PTR_W-1:0] pdrxq_ptr_t;

    // One cycle of the decoded receive stream.
    typedef struct packed {
        logic sop;
        logic [2:0] sop_kind;
        logic byte_valid;
        logic [7:0] byte_data;
        logic eop;
        logic crc_good;
        logic line_idle;
        logic [2:0] stored_message_id;
        logic is_goodcrc;
    } pdrxq_rx_s;

    // Transmitter state seen by the duplicate filter.
    typedef struct packed {
        logic auto_retry_active;
        logic awaiting_ack;
    } pdrxq_tx_s;

    typedef enum logic [1:0] {
        WR_IDLE,
        WR_RECEIVE,
        WR_DISCARD
    } pdrxq_wr_state_e;

endpackage : pdrxq_pkg

// file: rtl/pdrxq_writer.sv
// Purpose: Write side of the receive packet queue with an APB register port.
// Assumes: Receive stream inputs are synchronous and one byte per valid cycle.
// Notes: Queue RAM is flip-flops; the data register pops one byte per read.
`timescale 1ns/10ps

// Functional notes
// - Status byte zero means the entry and its length carry nothing valid.
// - Status bit 0 marks valid; bits 6:4 hold the received frame kind.
// - Frame kinds encode 0 to 4; codes 5 to 7 never produced.
// - Reading an empty queue returns zero.
// - Stored byte count includes the four trailing CRC bytes.
// - Block-read mode stores length first, status second, length plus one.
// - At frame start the current pointer becomes head plus two.
// - Each byte goes to the current pointer, which then increments and wraps.
// - Good end of frame writes status at head, count at head plus one.
// - Then head takes current pointer, head-plus-one takes current plus one.
// - Line idle without end of frame drops the packet, header untouched.
// - Bad CRC at end of frame drops the packet, header untouched.
// - Bytes beyond free space flag overrun, are discarded, pointer holds.
// - No room for the two header bytes flags overrun, pointer not loaded.
// - Bytes beyond maximum size flag oversize, are discarded, pointer holds.
// - Wrap bits on every pointer separate full from empty and header room.
// - Pointers and flags are readable; pointers are software writable.
// - Setting then clearing receiver reset returns pointers to initial state.
// - Auto-ack duplicate message ID is dropped, flagged and acknowledged again.
// - Repeated packet with bad CRC or no end is corrupt; ID kept.
// - Non-acknowledge message while awaiting acknowledge with retry is dropped.
// - Separate duplicate and corrupt counts; above 127 sets debug flag.
// - Queue RAM is 128 bytes holding several packets with headers.
// - Data becomes visible to the reader only after validation.
module pdrxq_writer (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Receive stream and transmitter state
    input wire pdrxq_pkg::pdrxq_rx_s i_rx,
    input wire pdrxq_pkg::pdrxq_tx_s i_tx,
    // Status toward the rest of the MAC
    output logic o_ack_request,
    output logic o_not_empty
);
    // Queue storage and pointers.
    logic [7:0] mem_reg [pdrxq_pkg::RAM_DEPTH];
    logic [7:0] mem_next [pdrxq_pkg::RAM_DEPTH];
    pdrxq_pkg::pdrxq_ptr_t rd_reg, rd_next;
    pdrxq_pkg::pdrxq_ptr_t head_reg, head_next;
    pdrxq_pkg::pdrxq_ptr_t head_p1_reg, head_p1_next;
    pdrxq_pkg::pdrxq_ptr_t cur_reg, cur_next;
    pdrxq_pkg::pdrxq_wr_state_e state_reg, state_next;
    logic [7:0] count_reg, count_next;
    logic [2:0] kind_reg, kind_next;
    logic bad_reg, bad_next;

    // Software registers and flags.
    logic [2:0] ctrl_reg, ctrl_next;
    logic [7:0] max_size_reg, max_size_next;
    logic overrun_reg, overrun_next;
    logic oversize_reg, oversize_next;
    logic dropped_reg, dropped_next;
    logic debug_reg, debug_next;
    logic [2:0] stored_message_id_reg [pdrxq_pkg::KIND_COUNT];
    logic [2:0] stored_message_id_next [pdrxq_pkg::KIND_COUNT];
    logic [pdrxq_pkg::KIND_COUNT-1:0] id_seen_reg, id_seen_next;

    // Bus answer and output flops.
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic ack_reg, ack_next;
    logic not_empty_reg, not_empty_next;

    // Event strobes for the counters.
    logic dup_event, corrupt_event, dup_clear, corrupt_clear;
    logic [7:0] dup_count, corrupt_count;

    pdrxq_event_counter u_dup_counter (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_clear(dup_clear),
        .i_inc(dup_event),
        .o_count(dup_count)
    );

    pdrxq_event_counter u_corrupt_counter (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_clear(corrupt_clear),
        .i_inc(corrupt_event),
        .o_count(corrupt_count)
    );

    logic bus_done, bus_wr, bus_rd;
    assign bus_done = i_psel && i_penable && pready_reg;
    assign bus_wr = bus_done && i_pwrite;
    assign bus_rd = bus_done && !i_pwrite;
    assign dup_clear = bus_wr && i_paddr == pdrxq_pkg::OFS_DUP_CNT;
    assign corrupt_clear = bus_wr && i_paddr == pdrxq_pkg::OFS_CORRUPT_CNT;

    // Write side, duplicate filter and pointers.
    always_comb begin
        logic [7:0] used;
        logic [7:0] stat_byte;
        logic [7:0] len_byte;
        logic is_dup;
        logic rx_reset;
        used = 8'h00;
        stat_byte = 8'h00;
        len_byte = 8'h00;
        is_dup = 1'b0;
        rx_reset = ctrl_reg[pdrxq_pkg::CTRL_RECEIVER_RESET_BIT];
        mem_next = mem_reg;
        rd_next = rd_reg;
        head_next = head_reg;
        head_p1_next = head_p1_reg;
        cur_next = cur_reg;
        state_next = state_reg;
        count_next = count_reg;
        kind_next = kind_reg;
        bad_next = bad_reg;
        stored_message_id_next = stored_message_id_reg;
        id_seen_next = id_seen_reg;
        ack_next = 1'b0;
        dup_event = 1'b0;
        corrupt_event = 1'b0;
        overrun_next = overrun_reg;
        oversize_next = oversize_reg;
        dropped_next = dropped_reg;
        // Clearing before the events below lets a same-cycle hardware set win.
        if (bus_wr && i_paddr == pdrxq_pkg::OFS_STATUS) begin
            overrun_next = overrun_reg && !i_pwdata[pdrxq_pkg::STAT_OVERRUN_BIT];
            oversize_next = oversize_reg && !i_pwdata[pdrxq_pkg::STAT_OVERSIZE_BIT];
            dropped_next = dropped_reg && !i_pwdata[pdrxq_pkg::STAT_DROPPED_BIT];
        end
        // Software writes to pointers come first so the hardware can override.
        if (bus_wr) begin
            unique case (i_paddr)
                pdrxq_pkg::OFS_RD_PTR: rd_next = i_pwdata[7:0];
                pdrxq_pkg::OFS_HEAD_PTR: head_next = i_pwdata[7:0];
                pdrxq_pkg::OFS_HEAD_P1_PTR: head_p1_next = i_pwdata[7:0];
                pdrxq_pkg::OFS_CUR_WR_PTR: cur_next = i_pwdata[7:0];
                default: ;
            endcase
        end
        if (bus_rd && i_paddr == pdrxq_pkg::OFS_FIFO_DATA && rd_reg != head_reg) begin
            rd_next = rd_reg + 8'h01;
        end
        unique case (state_reg)
            pdrxq_pkg::WR_IDLE: begin
                if (i_rx.sop) begin
                    // Distance from reader to head; the wrap bit makes this exact.
                    used = head_reg - rd_reg;
                    if (pdrxq_pkg::FULL_USED - used < pdrxq_pkg::HEADER_BYTES) begin
                        overrun_next = 1'b1;
                        state_next = pdrxq_pkg::WR_DISCARD;
                    end else begin
                        cur_next = head_reg + pdrxq_pkg::HEADER_BYTES;
                        count_next = 8'h00;
                        kind_next = i_rx.sop_kind;
                        bad_next = 1'b0;
                        state_next = pdrxq_pkg::WR_RECEIVE;
                    end
                end
            end
            pdrxq_pkg::WR_RECEIVE: begin
                if (i_rx.byte_valid) begin
                    used = cur_reg - rd_reg;
                    if (count_reg >= max_size_reg) begin
                        oversize_next = 1'b1;
                        bad_next = 1'b1;
                    end else if (used == pdrxq_pkg::FULL_USED) begin
                        overrun_next = 1'b1;
                        bad_next = 1'b1;
                    end else begin
                        mem_next[cur_reg[pdrxq_pkg::ADDR_W-1:0]] = i_rx.byte_data;
                        cur_next = cur_reg + 8'h01;
                        count_next = count_reg + 8'h01;
                    end
                end
                if (i_rx.eop) begin
                    state_next = pdrxq_pkg::WR_IDLE;
                    if (!i_rx.crc_good) begin
                        corrupt_event = 1'b1;
                    end else if (!bad_reg) begin
                        if (i_tx.auto_retry_active && i_tx.awaiting_ack) begin
                            // An answer awaited with auto retry active is never queued.
                            is_dup = 1'b1;
                            if (!i_rx.is_goodcrc) begin
                                dropped_next = 1'b1;
                                dup_event = 1'b1;
                            end
                        end else if (ctrl_reg[pdrxq_pkg::CTRL_AUTO_ACK_BIT]
                                     && !i_rx.is_goodcrc
                                     && id_seen_reg[kind_reg]
                                     && stored_message_id_reg[kind_reg] == i_rx.stored_message_id) begin
                            is_dup = 1'b1;
                            dropped_next = 1'b1;
                            dup_event = 1'b1;
                            ack_next = 1'b1;
                        end
                        if (!is_dup) begin
                            stat_byte[pdrxq_pkg::QSTAT_VALID_BIT] = 1'b1;
                            stat_byte[pdrxq_pkg::QSTAT_KIND_LSB +: 3] = kind_reg;
                            if (ctrl_reg[pdrxq_pkg::CTRL_BLOCK_READ_BIT]) begin
                                len_byte = count_reg + 8'h01;
                                mem_next[head_reg[pdrxq_pkg::ADDR_W-1:0]] = len_byte;
                                mem_next[head_p1_reg[pdrxq_pkg::ADDR_W-1:0]] = stat_byte;
                            end else begin
                                mem_next[head_reg[pdrxq_pkg::ADDR_W-1:0]] = stat_byte;
                                mem_next[head_p1_reg[pdrxq_pkg::ADDR_W-1:0]] = count_reg;
                            end
                            head_next = cur_reg;
                            head_p1_next = cur_reg + 8'h01;
                            if (!i_rx.is_goodcrc) begin
                                stored_message_id_next[kind_reg] = i_rx.stored_message_id;
                                id_seen_next[kind_reg] = 1'b1;
                                ack_next = ctrl_reg[pdrxq_pkg::CTRL_AUTO_ACK_BIT];
                            end
                        end
                    end
                end else if (i_rx.line_idle) begin
                    corrupt_event = 1'b1;
                    state_next = pdrxq_pkg::WR_IDLE;
                end
            end
            pdrxq_pkg::WR_DISCARD: begin
                if (i_rx.eop || i_rx.line_idle) begin
                    state_next = pdrxq_pkg::WR_IDLE;
                end
            end
            default: state_next = pdrxq_pkg::WR_IDLE;
        endcase
        // Held in reset while the bit is set, so clearing it releases fresh pointers.
        if (rx_reset) begin
            rd_next = pdrxq_pkg::PTR_RESET;
            head_next = pdrxq_pkg::PTR_RESET;
            head_p1_next = pdrxq_pkg::HEAD_P1_RESET;
            cur_next = pdrxq_pkg::PTR_RESET;
            state_next = pdrxq_pkg::WR_IDLE;
            ack_next = 1'b0;
            dup_event = 1'b0;
            corrupt_event = 1'b0;
        end
        not_empty_next = rd_next != head_next;
    end

    // Debug flag, control registers and bus answer.
    always_comb begin
        logic debug_set;
        debug_set = dup_count > pdrxq_pkg::COUNT_DEBUG_LIMIT
                    || corrupt_count > pdrxq_pkg::COUNT_DEBUG_LIMIT;
        debug_next = debug_reg || debug_set;
        ctrl_next = ctrl_reg;
        max_size_next = max_size_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        if (bus_wr) begin
            if (i_paddr == pdrxq_pkg::OFS_CTRL) begin
                ctrl_next = i_pwdata[2:0];
            end
            if (i_paddr == pdrxq_pkg::OFS_MAX_SIZE) begin
                max_size_next = i_pwdata[7:0];
            end
            if (i_paddr == pdrxq_pkg::OFS_STATUS && !debug_set
                && i_pwdata[pdrxq_pkg::STAT_DEBUG_EVENT_BIT]) begin
                debug_next = 1'b0;
            end
        end
        // Answer one cycle into the access phase; pready then drops for one cycle.
        if (i_psel && i_penable && !pready_reg) begin
            pready_next = 1'b1;
            prdata_next = 32'h0000_0000;
            unique case (i_paddr)
                pdrxq_pkg::OFS_CTRL: prdata_next[2:0] = ctrl_reg;
                pdrxq_pkg::OFS_MAX_SIZE: prdata_next[7:0] = max_size_reg;
                pdrxq_pkg::OFS_STATUS: prdata_next[4:0] = {debug_reg, dropped_reg,
                                                           oversize_reg, overrun_reg,
                                                           not_empty_reg};
                pdrxq_pkg::OFS_FIFO_DATA: begin
                    if (rd_reg != head_reg) begin
                        prdata_next[7:0] = mem_reg[rd_reg[pdrxq_pkg::ADDR_W-1:0]];
                    end else begin
                        prdata_next[7:0] = pdrxq_pkg::QSTAT_EMPTY_VALUE;
                    end
                end
                pdrxq_pkg::OFS_RD_PTR: prdata_next[7:0] = rd_reg;
                pdrxq_pkg::OFS_HEAD_PTR: prdata_next[7:0] = head_reg;
                pdrxq_pkg::OFS_HEAD_P1_PTR: prdata_next[7:0] = head_p1_reg;
                pdrxq_pkg::OFS_CUR_WR_PTR: prdata_next[7:0] = cur_reg;
                pdrxq_pkg::OFS_DUP_CNT: prdata_next[7:0] = dup_count;
                pdrxq_pkg::OFS_CORRUPT_CNT: prdata_next[7:0] = corrupt_count;
                pdrxq_pkg::OFS_STORED_MESSAGE_ID: prdata_next[19:0] = {id_seen_reg, stored_message_id_reg[4],
                                                            stored_message_id_reg[3], stored_message_id_reg[2],
                                                            stored_message_id_reg[1], stored_message_id_reg[0]};
                default: pslverr_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            for (int i = 0; i < pdrxq_pkg::RAM_DEPTH; i++) begin
                mem_reg[i] <= 8'h00;
            end
            for (int k = 0; k < pdrxq_pkg::KIND_COUNT; k++) begin
                stored_message_id_reg[k] <= 3'h0;
            end
            rd_reg <= pdrxq_pkg::PTR_RESET;
            head_reg <= pdrxq_pkg::PTR_RESET;
            head_p1_reg <= pdrxq_pkg::HEAD_P1_RESET;
            cur_reg <= pdrxq_pkg::PTR_RESET;
            state_reg <= pdrxq_pkg::WR_IDLE;
            count_reg <= 8'h00;
            kind_reg <= pdrxq_pkg::KIND_PLAIN;
            bad_reg <= 1'b0;
            id_seen_reg <= '0;
            ctrl_reg <= pdrxq_pkg::CTRL_RESET;
            max_size_reg <= pdrxq_pkg::MAX_SIZE_RESET;
            overrun_reg <= 1'b0;
            oversize_reg <= 1'b0;
            dropped_reg <= 1'b0;
            debug_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            ack_reg <= 1'b0;
            not_empty_reg <= 1'b0;
        end else begin
            mem_reg <= mem_next;
            stored_message_id_reg <= stored_message_id_next;
            rd_reg <= rd_next;
            head_reg <= head_next;
            head_p1_reg <= head_p1_next;
            cur_reg <= cur_next;
            state_reg <= state_next;
            count_reg <= count_next;
            kind_reg <= kind_next;
            bad_reg <= bad_next;
            id_seen_reg <= id_seen_next;
            ctrl_reg <= ctrl_next;
            max_size_reg <= max_size_next;
            overrun_reg <= overrun_next;
            oversize_reg <= oversize_next;
            dropped_reg <= dropped_next;
            debug_reg <= debug_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            ack_reg <= ack_next;
            not_empty_reg <= not_empty_next;
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_ack_request = ack_reg;
    assign o_not_empty = not_empty_reg;
endmodule : pdrxq_writer

// file: testbench/pdrxq_rx_src.sv
// Purpose: Decoded receive stream source.
// Assumes: One byte per cycle; the end marker has a cycle of its own.
// Notes: Data lines keep changing outside valid bytes.
`timescale 1ns/10ps
module pdrxq_rx_src (
    // Clock
    input wire logic i_core_clk,
    // Decoded stream
    output pdrxq_pkg::pdrxq_rx_s o_rx
);
    initial o_rx = '0;
    task automatic send(input logic [2:0] kind, input logic [7:0] n, b,
                        input logic good, idle, input logic [2:0] id);
        pdrxq_pkg::pdrxq_rx_s r;
        r = '0;
        r.sop = 1'b1;
        r.sop_kind = kind;
        @(posedge i_core_clk) o_rx <= r;
        r.sop = 1'b0;
        r.byte_valid = 1'b1;
        for (int i = 0; i < n; i++) begin
            r.byte_data = b + i[7:0];
            @(posedge i_core_clk) o_rx <= r;
        end
        r.byte_valid = 1'b0;
        r.eop = !idle;
        r.line_idle = idle;
        r.crc_good = good;
        r.stored_message_id = id;
        repeat (5) begin
            r.byte_data = ~r.byte_data;
            @(posedge i_core_clk) o_rx <= r;
            r.eop = 1'b0;
        end
    endtask : send
endmodule : pdrxq_rx_src

// file: testbench/pdrxq_writer_asserts.sv
// Purpose: Port checks for the receive queue writer.
// Assumes: Two-cycle APB access phase.
// Notes: Bound into every writer instance.
`timescale 1ns/10ps
module pdrxq_writer_asserts (
    // Clock, reset and APB
    input wire logic i_core_clk, i_reset, i_psel, i_penable, i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata, o_prdata,
    // Status
    input wire logic o_pready, o_pslverr, o_ack_request, o_not_empty,
    // Receive stream and transmitter state
    input wire pdrxq_pkg::pdrxq_rx_s i_rx,
    input wire pdrxq_pkg::pdrxq_tx_s i_tx
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);
    answer_time_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("pready late");
    answer_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready too long");
    refuse_zero_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("bad refusal");
    byte_wide_a: assert property (o_pready && i_paddr != pdrxq_pkg::OFS_STORED_MESSAGE_ID |->
        o_prdata[31:8] == 24'h0) else $error("upper read bits set");
    empty_read_a: assert property (o_pready && !i_pwrite && !o_not_empty &&
        i_paddr == pdrxq_pkg::OFS_FIFO_DATA |-> o_prdata == 32'h0) else $error("empty read");
    ack_pulse_a: assert property (o_ack_request |=> !o_ack_request)
        else $error("ack too long");
    ack_cause_a: assert property (o_ack_request |-> $past(i_rx.eop) && $past(i_rx.crc_good))
        else $error("ack without good end");
    show_cause_a: assert property ($rose(o_not_empty) |->
        $past(i_rx.eop) || $past(i_psel) || $past(i_psel, 2)) else $error("early data");
    pop_cause_a: assert property ($fell(o_not_empty) |->
        $past(i_psel) || $past(i_psel, 2)) else $error("data lost");
    cover property (o_ack_request);
    cover property ($rose(o_not_empty));
    cover property (o_pslverr);
endmodule : pdrxq_writer_asserts

bind pdrxq_writer pdrxq_writer_asserts i_chk (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_ack_request(o_ack_request),
    .o_not_empty(o_not_empty), .i_rx(i_rx), .i_tx(i_tx));

// file: testbench/tb.sv
// Purpose: Self-checking bench for the receive queue writer.
// Assumes: Reads are compared in order against queued expectations.
// Notes: Payload byte i of a packet is its base plus i.
`timescale 1ns/10ps
module tb;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, hp = 8'h00, n, b;
    logic [31:0] pwdata = 32'h0, o_prdata, e;
    logic o_pready, ack;
    pdrxq_pkg::pdrxq_rx_s rx;
    pdrxq_pkg::pdrxq_tx_s tx = '0;
    logic [31:0] exp_q[$];
    int num_errors = 0, n_checks = 0, n_acks = 0;
    always #2.5 i_core_clk = ~i_core_clk;
    pdrxq_rx_src i_src (.i_core_clk(i_core_clk), .o_rx(rx));
    pdrxq_writer i_dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(), .i_rx(rx), .i_tx(tx),
        .o_ack_request(ack), .o_not_empty());
    task automatic results();
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_core_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 40);
        if (o_pready !== 1'b1) begin
            num_errors++;
            results();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic rf(input logic [31:0] x);
        rd(pdrxq_pkg::OFS_FIFO_DATA, x);
    endtask : rf
    task automatic rdpkt(input logic [2:0] k, input logic [7:0] n, b, input logic blk);
        if (blk) rf({24'h0, n + 8'h01});
        rf({25'h0, k, 4'h1});
        if (!blk) rf({24'h0, n});
        for (int i = 0; i < n; i++) rf({24'h0, b + i[7:0]});
        hp = hp + n + 8'h02;
    endtask : rdpkt
    always @(posedge i_core_clk) begin
        if (ack === 1'b1) n_acks++;
        if (psel && penable && o_pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            n_checks++;
            if (o_prdata !== e) begin
                $display("BAD prdata at %h: expected %h seen %h", paddr, e, o_prdata);
                num_errors++;
            end
        end
    end
    initial begin
        void'($urandom(31947));
        repeat (8) @(posedge i_core_clk);
        i_reset <= 1'b0;
        rd(pdrxq_pkg::OFS_MAX_SIZE, 32'h80);
        rf(32'h0);
        rd(8'h3C, 32'h0);
        for (int k = 0; k < 2 * pdrxq_pkg::KIND_COUNT; k++) begin
            n = 8'($urandom_range(20, 4));
            b = 8'($urandom);
            apb(1'b1, pdrxq_pkg::OFS_CTRL, {31'h0, k[0]});
            i_src.send(3'(k % 5), n, b, 1'b1, 1'b0, 3'h0);
            rdpkt(3'(k % 5), n, b, k[0]);
        end
        i_src.send(3'h0, 8'h06, b, 1'b0, 1'b0, 3'h0);
        rf(32'h0);
        rd(pdrxq_pkg::OFS_CORRUPT_CNT, 32'h1);
        i_src.send(3'h1, 8'h06, b, 1'b1, 1'b1, 3'h0);
        rf(32'h0);
        apb(1'b1, pdrxq_pkg::OFS_MAX_SIZE, 32'h4);
        i_src.send(3'h2, 8'h08, b, 1'b1, 1'b0, 3'h0);
        rd(pdrxq_pkg::OFS_STATUS, 32'h4);
        apb(1'b1, pdrxq_pkg::OFS_STATUS, 32'h1F);
        apb(1'b1, pdrxq_pkg::OFS_MAX_SIZE, 32'h80);
        apb(1'b1, pdrxq_pkg::OFS_CTRL, 32'h2);
        i_src.send(3'h0, 8'h05, b, 1'b1, 1'b0, 3'h3);
        rdpkt(3'h0, 8'h05, b, 1'b0);
        i_src.send(3'h0, 8'h05, b, 1'b1, 1'b0, 3'h3);
        rd(pdrxq_pkg::OFS_STATUS, 32'h8);
        rd(pdrxq_pkg::OFS_DUP_CNT, 32'h1);
        tx <= 2'b11;
        i_src.send(3'h1, 8'h05, b, 1'b1, 1'b0, 3'h4);
        rf(32'h0);
        rd(pdrxq_pkg::OFS_DUP_CNT, 32'h2);
        rd(pdrxq_pkg::OFS_HEAD_PTR, {24'h0, hp});
        rd(pdrxq_pkg::OFS_RD_PTR, {24'h0, hp});
        apb(1'b1, pdrxq_pkg::OFS_CTRL, 32'h4);
        apb(1'b1, pdrxq_pkg::OFS_CTRL, 32'h0);
        rd(pdrxq_pkg::OFS_CUR_WR_PTR, 32'h0);
        rd(pdrxq_pkg::OFS_HEAD_P1_PTR, 32'h1);
        @(posedge i_core_clk);
        n_checks++;
        if (n_acks != 2) begin
            $display("BAD ack count: expected 2 seen %0d", n_acks);
            num_errors++;
        end
        results();
    end
endmodule : tb
